// ==== common/usrc_pkg.sv ====
// Package: register offsets, field positions, reset values and interrupt codes for the status block
package usrc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [3:0] OFF_ID = 4'h0;
	localparam logic [3:0] OFF_LINE = 4'h1;
	localparam logic [3:0] OFF_MODEM = 4'h2;
	localparam logic [3:0] OFF_TXHOLD = 4'h3;
	localparam logic [3:0] OFF_IRQ_STAT = 4'h4;
	localparam logic [3:0] OFF_IRQ_EN = 4'h5;
	localparam logic [3:0] OFF_IRQ_CLR = 4'h6;
	localparam logic [3:0] OFF_SRC_EN = 4'h7;

	// Line-status field positions
	localparam int LS_RXRDY = 0;
	localparam int LS_OVERRUN = 1;
	localparam int LS_PARITY = 2;
	localparam int LS_FRAMING = 3;
	localparam int LS_BREAK = 4;
	localparam int LS_THEMPTY = 5;
	localparam logic [7:0] LS_ERR_MASK = 8'h1e;

	// Modem-status field positions: deltas low nibble, levels high nibble
	localparam int MS_DCTS = 0;
	localparam int MS_DDSR = 1;
	localparam int MS_TERI = 2;
	localparam int MS_DDCD = 3;
	localparam int MS_CTS = 4;
	localparam int MS_DSR = 5;
	localparam int MS_RI = 6;
	localparam int MS_DCD = 7;
	localparam logic [7:0] MS_DELTA_MASK = 8'h0f;

	// Interrupt identification codes: bit0 high means none pending
	localparam logic [3:0] ID_NONE = 4'h1;
	localparam logic [3:0] ID_LINE = 4'h6;
	localparam logic [3:0] ID_RXDATA = 4'h4;
	localparam logic [3:0] ID_THEMPTY = 4'h2;
	localparam logic [3:0] ID_MODEM = 4'h0;

	// Source-enable bits
	localparam int SE_LINE = 0;
	localparam int SE_RX = 1;
	localparam int SE_TX = 2;
	localparam int SE_MODEM = 3;
	localparam logic [3:0] SRC_EN_RST = 4'h0;

	// Sticky event bits in the block interrupt status
	localparam int EV_ERR = 0;
	localparam int EV_DELTA = 1;
	localparam int EV_THEMPTY = 2;
	localparam int EV_RX = 3;
	localparam int EV_W = 4;
	localparam logic [3:0] IRQ_EN_RST = 4'h0;

	typedef enum logic [2:0] {
		USRC_SRC_NONE,
		USRC_SRC_LINE,
		USRC_SRC_RX,
		USRC_SRC_TX,
		USRC_SRC_MODEM
	} usrc_src_e;

	typedef struct packed {
		logic rx_ready;
		logic overrun;
		logic parity_error;
		logic framing_error;
		logic break_indication;
	} usrc_rx_ev_s;

	typedef struct packed {
		logic dcd;
		logic ri;
		logic dsr;
		logic cts;
	} usrc_modem_s;
endpackage : usrc_pkg

// ==== hw/usrc_sticky.sv ====
// Module: bank of sticky flags, hardware set wins over a read clear
module usrc_sticky #(
	parameter int W = 4
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	output logic [W-1:0] flag_o
);
	logic [W-1:0] next_flag;

	// A set arriving with the clear survives it
	assign next_flag = (flag_o & ~clr_i) | set_i;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			flag_o <= '0;
		end else begin
			flag_o <= next_flag;
		end
	end
endmodule // usrc_sticky

// ==== hw/usrc_prio.sv ====
// Module: interrupt priority selector for the identification register
module usrc_prio (
	input wire logic line_i,
	input wire logic rx_i,
	input wire logic tx_i,
	input wire logic modem_i,
	output usrc_pkg::usrc_src_e src_o,
	output logic [3:0] code_o
);
	// Line errors, then receive data, then holding empty, then modem change
	assign src_o = line_i ? usrc_pkg::USRC_SRC_LINE :
		rx_i ? usrc_pkg::USRC_SRC_RX :
		tx_i ? usrc_pkg::USRC_SRC_TX :
		modem_i ? usrc_pkg::USRC_SRC_MODEM : usrc_pkg::USRC_SRC_NONE;

	always_comb begin
		case (src_o)
			usrc_pkg::USRC_SRC_LINE: code_o = usrc_pkg::ID_LINE;
			usrc_pkg::USRC_SRC_RX: code_o = usrc_pkg::ID_RXDATA;
			usrc_pkg::USRC_SRC_TX: code_o = usrc_pkg::ID_THEMPTY;
			usrc_pkg::USRC_SRC_MODEM: code_o = usrc_pkg::ID_MODEM;
			default: code_o = usrc_pkg::ID_NONE;
		endcase
	end
endmodule // usrc_prio

// ==== hw/usrc_top.sv ====
// Module: serial port status, read-clear and interrupt identification logic
module usrc_top #(
	parameter bit HAS_MODEM = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [usrc_pkg::ADDR_W-1:0] addr_i,
	input wire logic [usrc_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [usrc_pkg::DATA_W-1:0] rdata_o,
	input wire usrc_pkg::usrc_rx_ev_s rx_ev_i,
	input wire logic rx_taken_i,
	input wire logic tx_hold_free_i,
	input wire usrc_pkg::usrc_modem_s modem_i,
	output logic tx_load_o,
	output logic [usrc_pkg::DATA_W-1:0] tx_data_o,
	output logic irq_o
);
	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		return a == off;
	endfunction

	logic rd_id;
	logic rd_line;
	logic rd_modem;
	logic wr_tx;
	logic wr_irq_en;
	logic wr_irq_clr;
	logic wr_src_en;

	assign rd_id = rd_i && hit(addr_i, usrc_pkg::OFF_ID);
	assign rd_line = rd_i && hit(addr_i, usrc_pkg::OFF_LINE);
	assign rd_modem = rd_i && hit(addr_i, usrc_pkg::OFF_MODEM);
	assign wr_tx = wr_i && hit(addr_i, usrc_pkg::OFF_TXHOLD);
	assign wr_irq_en = wr_i && hit(addr_i, usrc_pkg::OFF_IRQ_EN);
	assign wr_irq_clr = wr_i && hit(addr_i, usrc_pkg::OFF_IRQ_CLR);
	assign wr_src_en = wr_i && hit(addr_i, usrc_pkg::OFF_SRC_EN);

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [3:0] src_en;
	logic [usrc_pkg::EV_W-1:0] irq_en;
	logic rx_avail;
	logic [usrc_pkg::DATA_W-1:0] rd_word;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			src_en <= usrc_pkg::SRC_EN_RST;
			irq_en <= usrc_pkg::IRQ_EN_RST;
		end else begin
			if (wr_src_en) begin
				src_en <= wdata_i[3:0];
			end
			if (wr_irq_en) begin
				irq_en <= wdata_i[usrc_pkg::EV_W-1:0];
			end
		end
	end

	// Receive data flag: new character wins over the consumer's take
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_avail <= 1'b0;
		end else begin
			rx_avail <= rx_ev_i.rx_ready | (rx_avail & ~rx_taken_i);
		end
	end

	// ------------------------------------------------------------
	// Line-status error bits
	// ------------------------------------------------------------
	logic [3:0] err_set;
	logic [3:0] err_clr;
	logic [3:0] err_flags;

	// Errors are only posted together with a received character
	assign err_set = rx_ev_i.rx_ready ? {rx_ev_i.break_indication, rx_ev_i.framing_error,
		rx_ev_i.parity_error, rx_ev_i.overrun} : 4'h0;
	assign err_clr = {4{rd_line}};

	usrc_sticky #(.W(4)) u_err (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.set_i(err_set),
		.clr_i(err_clr),
		.flag_o(err_flags)
	);

	// ------------------------------------------------------------
	// Modem delta bits
	// ------------------------------------------------------------
	usrc_pkg::usrc_modem_s modem_q;
	logic [3:0] delta_set;
	logic [3:0] delta_clr;
	logic [3:0] delta_flags;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			modem_q <= '0;
		end else begin
			modem_q <= modem_i;
		end
	end

	// Ring indicator flags only its trailing edge
	assign delta_set = HAS_MODEM ? {modem_q.dcd ^ modem_i.dcd, modem_q.ri & ~modem_i.ri,
		modem_q.dsr ^ modem_i.dsr, modem_q.cts ^ modem_i.cts} : 4'h0;
	assign delta_clr = {4{rd_modem}};

	usrc_sticky #(.W(4)) u_delta (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.set_i(delta_set),
		.clr_i(delta_clr),
		.flag_o(delta_flags)
	);

	// ------------------------------------------------------------
	// Holding-empty pending and priority
	// ------------------------------------------------------------
	logic hold_free_q;
	logic thempty_pend;
	logic thempty_rise;
	logic thempty_id_clr;
	logic next_thempty;
	usrc_pkg::usrc_src_e top_src;
	logic [3:0] id_code;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hold_free_q <= 1'b1;
		end else begin
			hold_free_q <= tx_hold_free_i;
		end
	end

	assign thempty_rise = tx_hold_free_i & ~hold_free_q;

	usrc_prio u_prio (
		.line_i(src_en[usrc_pkg::SE_LINE] & (|err_flags)),
		.rx_i(src_en[usrc_pkg::SE_RX] & rx_avail),
		.tx_i(src_en[usrc_pkg::SE_TX] & thempty_pend),
		.modem_i(HAS_MODEM & src_en[usrc_pkg::SE_MODEM] & (|delta_flags)),
		.src_o(top_src),
		.code_o(id_code)
	);

	// Ident read clears it only when HAS_MODEM is set and holding-empty is the reported source; otherwise it stays pending
	assign thempty_id_clr = HAS_MODEM && rd_id && top_src == usrc_pkg::USRC_SRC_TX;
	assign next_thempty = thempty_rise | (thempty_pend & ~thempty_id_clr & ~wr_tx);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			thempty_pend <= 1'b0;
		end else begin
			thempty_pend <= next_thempty;
		end
	end

	// ------------------------------------------------------------
	// Block interrupt status, enable and clear
	// ------------------------------------------------------------
	logic [usrc_pkg::EV_W-1:0] ev_set;
	logic [usrc_pkg::EV_W-1:0] ev_status;
	logic [usrc_pkg::EV_W-1:0] ev_clr;

	assign ev_set = {rx_ev_i.rx_ready, thempty_rise, |delta_set, |err_set};
	assign ev_clr = wr_irq_clr ? wdata_i[usrc_pkg::EV_W-1:0] : '0;

	usrc_sticky #(.W(usrc_pkg::EV_W)) u_ev (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.set_i(ev_set),
		.clr_i(ev_clr),
		.flag_o(ev_status)
	);

	// ------------------------------------------------------------
	// Read data and outputs
	// ------------------------------------------------------------
	logic [usrc_pkg::DATA_W-1:0] line_word;
	logic [usrc_pkg::DATA_W-1:0] modem_word;

	assign line_word = {2'b00, hold_free_q, err_flags, rx_avail};
	// Levels are live and unaffected by the read clear
	assign modem_word = HAS_MODEM ? {modem_q.dcd, modem_q.ri, modem_q.dsr, modem_q.cts,
		delta_flags} : 8'h00;

	// Contents before the clear are captured in the same cycle as the read strobe
	always_comb begin
		case (addr_i)
			usrc_pkg::OFF_ID: rd_word = {4'h0, id_code};
			usrc_pkg::OFF_LINE: rd_word = line_word;
			usrc_pkg::OFF_MODEM: rd_word = modem_word;
			usrc_pkg::OFF_IRQ_STAT: rd_word = {4'h0, ev_status};
			usrc_pkg::OFF_IRQ_EN: rd_word = {4'h0, irq_en};
			usrc_pkg::OFF_SRC_EN: rd_word = {4'h0, src_en};
			default: rd_word = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 8'h00;
			tx_load_o <= 1'b0;
			tx_data_o <= 8'h00;
			irq_o <= 1'b0;
		end else begin
			rdata_o <= rd_i ? rd_word : 8'h00;
			tx_load_o <= wr_tx;
			tx_data_o <= wr_tx ? wdata_i : tx_data_o;
			irq_o <= |(ev_status & irq_en);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_line_read;
		rd_line && !rx_ev_i.rx_ready;
	endsequence

	property p_line_clear;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_line_read |=> err_flags == 4'h0;
	endproperty
	a_line_clear: assert property (p_line_clear) else $error("Line errors not cleared");

	property p_line_keep;
		@(posedge clk_i) disable iff (!rst_b_i)
		rd_line && rx_ev_i.rx_ready && rx_ev_i.parity_error |=> err_flags[1];
	endproperty
	a_line_keep: assert property (p_line_keep) else $error("Parity set lost on read");

	property p_line_data;
		@(posedge clk_i) disable iff (!rst_b_i)
		rd_line |=> rdata_o[4:1] == $past(err_flags);
	endproperty
	a_line_data: assert property (p_line_data) else $error("Read data not pre-clear");

	property p_modem_clear;
		@(posedge clk_i) disable iff (!rst_b_i)
		rd_modem && delta_set == 4'h0 |=> delta_flags == 4'h0;
	endproperty
	a_modem_clear: assert property (p_modem_clear) else $error("Deltas not cleared");

	property p_cts_delta;
		@(posedge clk_i) disable iff (!rst_b_i)
		HAS_MODEM && modem_i.cts != modem_q.cts |=> delta_flags[usrc_pkg::MS_DCTS];
	endproperty
	a_cts_delta: assert property (p_cts_delta) else $error("CTS change not flagged");

	property p_prio;
		@(posedge clk_i) disable iff (!rst_b_i)
		src_en[usrc_pkg::SE_RX] && rx_avail && err_flags == 4'h0 |-> id_code == usrc_pkg::ID_RXDATA;
	endproperty
	a_prio: assert property (p_prio) else $error("Receive data not on top");

	property p_id_clear;
		@(posedge clk_i) disable iff (!rst_b_i)
		thempty_id_clr && !thempty_rise |=> !thempty_pend;
	endproperty
	a_id_clear: assert property (p_id_clear) else $error("Holding-empty not cleared");

	property p_id_keep;
		@(posedge clk_i) disable iff (!rst_b_i)
		rd_id && thempty_pend && top_src != usrc_pkg::USRC_SRC_TX && !wr_tx |=> thempty_pend;
	endproperty
	a_id_keep: assert property (p_id_keep) else $error("Holding-empty lost");

	sequence s_tx_write;
		wr_tx && !thempty_rise;
	endsequence

	// Back-to-back writes are legal, so only the cycle after the write is checked
	property p_tx_write;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_tx_write |=> !thempty_pend && tx_load_o;
	endproperty
	a_tx_write: assert property (p_tx_write) else $error("Write kept holding-empty");

	property p_level;
		@(posedge clk_i) disable iff (!rst_b_i)
		HAS_MODEM && rd_modem |=> rdata_o[7:4] == $past({modem_q.dcd, modem_q.ri, modem_q.dsr,
			modem_q.cts});
	endproperty
	a_level: assert property (p_level) else $error("Modem levels wrong");

	property p_rdata_idle;
		@(posedge clk_i) disable iff (!rst_b_i)
		!rd_i |=> rdata_o == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("Read data without read");

	property p_id_data;
		@(posedge clk_i) disable iff (!rst_b_i)
		rd_id |=> rdata_o[3:0] == $past(id_code);
	endproperty
	a_id_data: assert property (p_id_data) else $error("Ident read not pre-clear");

	property p_thempty_post;
		@(posedge clk_i) disable iff (!rst_b_i)
		thempty_rise |=> thempty_pend;
	endproperty
	a_thempty_post: assert property (p_thempty_post) else $error("Holding-empty not posted");

	property p_err_post;
		@(posedge clk_i) disable iff (!rst_b_i)
		rx_ev_i.rx_ready && rx_ev_i.overrun |=> err_flags[0];
	endproperty
	a_err_post: assert property (p_err_post) else $error("Overrun not posted");

	property p_no_modem;
		@(posedge clk_i) disable iff (!rst_b_i)
		!HAS_MODEM && rd_modem |=> rdata_o == 8'h00;
	endproperty
	a_no_modem: assert property (p_no_modem) else $error("Modem word on plain port");

	property p_id_no_clear;
		@(posedge clk_i) disable iff (!rst_b_i)
		!HAS_MODEM && rd_id && thempty_pend && !wr_tx |=> thempty_pend;
	endproperty
	a_id_no_clear: assert property (p_id_no_clear) else $error("Plain port lost empty");

	property p_delta_keep;
		@(posedge clk_i) disable iff (!rst_b_i)
		rd_modem && delta_set[usrc_pkg::MS_DCTS] |=> delta_flags[usrc_pkg::MS_DCTS];
	endproperty
	a_delta_keep: assert property (p_delta_keep) else $error("CTS delta lost on read");

	sequence s_tx_top;
		src_en[usrc_pkg::SE_TX] && thempty_pend && err_flags == 4'h0 && !rx_avail;
	endsequence

	property p_modem_low;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_tx_top |-> id_code == usrc_pkg::ID_THEMPTY;
	endproperty
	a_modem_low: assert property (p_modem_low) else $error("Modem above holding-empty");
endmodule // usrc_top

// ==== verification/usrc_tb.sv ====
// Self-checking bench for the serial port status and read-clear block
module tb;
	timeunit 1ns;
	timeprecision 100ps;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
$display("Error %0t: got %h want %h", $time, (a), (b)); end end
	logic clk_i, rst_b_i, wr_i, rd_i, rx_taken_i, tx_hold_free_i, tx_load_o, irq_o;
	logic [3:0] addr_i, e, m, n;
	logic [7:0] wdata_i, rdata_o, rd2, tx_data_o, d, d2;
	logic [31:0] seed = 32'h60;
	logic [31:0] r;
	usrc_pkg::usrc_rx_ev_s rx_ev_i;
	usrc_pkg::usrc_modem_s modem_i;
	int failures, checks_done, k;
	// ----
	// Design under test
	// ----
	usrc_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_ev_i(rx_ev_i),
		.rx_taken_i(rx_taken_i), .tx_hold_free_i(tx_hold_free_i), .modem_i(modem_i),
		.tx_load_o(tx_load_o), .tx_data_o(tx_data_o), .irq_o(irq_o));
	// Instance without modem lines sees the same traffic
	usrc_top #(.HAS_MODEM(1'b0)) uut_b (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rd2), .rx_ev_i(rx_ev_i),
		.rx_taken_i(rx_taken_i), .tx_hold_free_i(tx_hold_free_i), .modem_i(modem_i),
		.tx_load_o(), .tx_data_o(), .irq_o());
	function automatic logic [7:0] ls_exp(input logic [3:0] x);
		return {3'h0, x[0], x[1], x[2], x[3], 1'b0};
	endfunction
	// Ring indicator only flags its trailing edge
	function automatic logic [3:0] ms_delta(input logic [3:0] o, input logic [3:0] v);
		return {o[3] ^ v[3], o[2] & ~v[2], o[1] ^ v[1], o[0] ^ v[0]};
	endfunction
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask
	task automatic bus_rd(input logic [3:0] a, input logic [4:0] ev);
		addr_i <= a;
		rd_i <= 1'b1;
		rx_ev_i <= ev;
		@(posedge clk_i);
		rd_i <= 1'b0;
		rx_ev_i <= '0;
		#1;
		d = rdata_o;
		d2 = rd2;
	endtask
	task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	// Released at the sampling edge so a following read may drive the same struct
	task automatic pulse_rx(input logic [3:0] x);
		rx_ev_i <= {1'b1, x};
		@(posedge clk_i);
		rx_ev_i <= '0;
		#1;
	endtask
	task automatic take();
		rx_taken_i <= 1'b1;
		cyc(1);
		rx_taken_i <= 1'b0;
		cyc(1);
	endtask
	// Holding register empties again: a fresh rising edge
	task automatic tx_rise();
		tx_hold_free_i <= 1'b0;
		cyc(2);
		tx_hold_free_i <= 1'b1;
		cyc(3);
	endtask
	task automatic chk_id(input logic [3:0] c);
		bus_rd(usrc_pkg::OFF_ID, '0);
		`CHK(d[3:0], c)
	endtask
	task automatic wait_irq(input logic v);
		int i;
		i = 0;
		while (irq_o !== v && i < 6) begin
			cyc(1);
			i++;
		end
		`CHK(irq_o, v)
		if (irq_o !== v) wrap_up();
	endtask
	// ----
	// Stimulus
	// ----
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		failures++;
		$display("Error %0t: run timed out", $time);
		wrap_up();
	end
	initial begin
		{addr_i, wdata_i, wr_i, rd_i, rx_taken_i, rst_b_i} = '0;
		rx_ev_i = '0;
		modem_i = '0;
		tx_hold_free_i = 1'b1;
		m = 4'h0;
		failures = 0;
		checks_done = 0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		cyc(1);
		for (k = 8; k < 16; k++) begin
			bus_rd(k[3:0], '0);
			`CHK(d, 8'h00)
		end
		$display("test map done");
		for (k = 0; k < 8; k++) begin
			r = rnd();
			e = (k == 0) ? 4'hf : r[7:4];
			pulse_rx(e);
			bus_rd(usrc_pkg::OFF_LINE, '0);
			`CHK(d & usrc_pkg::LS_ERR_MASK, ls_exp(e))
			`CHK(d2 & usrc_pkg::LS_ERR_MASK, ls_exp(e))
			bus_rd(usrc_pkg::OFF_LINE, '0);
			`CHK(d & usrc_pkg::LS_ERR_MASK, 8'h00)
			`CHK(d2 & usrc_pkg::LS_ERR_MASK, 8'h00)
		end
		bus_rd(usrc_pkg::OFF_LINE, 5'h14);
		`CHK(d & usrc_pkg::LS_ERR_MASK, 8'h00)
		bus_rd(usrc_pkg::OFF_LINE, '0);
		`CHK(d & usrc_pkg::LS_ERR_MASK, ls_exp(4'h4))
		take();
		$display("test line done");
		for (k = 0; k < 8; k++) begin
			r = rnd();
			n = (k == 0) ? 4'hf : (k == 1) ? 4'h0 : r[11:8];
			modem_i <= n;
			cyc(3);
			bus_rd(usrc_pkg::OFF_MODEM, '0);
			`CHK(d, {n, ms_delta(m, n)})
			`CHK(d2, 8'h00)
			bus_rd(usrc_pkg::OFF_MODEM, '0);
			`CHK(d, {n, 4'h0})
			m = n;
		end
		$display("test modem done");
		bus_wr(usrc_pkg::OFF_SRC_EN, 8'h0e);
		tx_rise();
		pulse_rx(4'h0);
		chk_id(usrc_pkg::ID_RXDATA);
		take();
		chk_id(usrc_pkg::ID_THEMPTY);
		chk_id(usrc_pkg::ID_NONE);
		`CHK(d2[3:0], usrc_pkg::ID_THEMPTY)
		tx_rise();
		modem_i <= ~m;
		m = ~m;
		cyc(3);
		chk_id(usrc_pkg::ID_THEMPTY);
		chk_id(usrc_pkg::ID_MODEM);
		bus_rd(usrc_pkg::OFF_MODEM, '0);
		chk_id(usrc_pkg::ID_NONE);
		tx_rise();
		r = rnd();
		bus_wr(usrc_pkg::OFF_TXHOLD, r[7:0]);
		`CHK(tx_load_o, 1'b1)
		`CHK(tx_data_o, r[7:0])
		chk_id(usrc_pkg::ID_NONE);
		bus_wr(usrc_pkg::OFF_SRC_EN, 8'h0f);
		pulse_rx(4'h4);
		chk_id(usrc_pkg::ID_LINE);
		bus_rd(usrc_pkg::OFF_LINE, '0);
		take();
		chk_id(usrc_pkg::ID_NONE);
		$display("test ident done");
		bus_wr(usrc_pkg::OFF_IRQ_CLR, 8'h0f);
		bus_wr(usrc_pkg::OFF_IRQ_EN, 8'h01);
		cyc(2);
		`CHK(irq_o, 1'b0)
		pulse_rx(4'h8);
		wait_irq(1'b1);
		bus_rd(usrc_pkg::OFF_IRQ_STAT, '0);
		`CHK(d[usrc_pkg::EV_ERR], 1'b1)
		bus_wr(usrc_pkg::OFF_IRQ_EN, 8'h00);
		wait_irq(1'b0);
		bus_wr(usrc_pkg::OFF_IRQ_EN, 8'h01);
		wait_irq(1'b1);
		bus_rd(usrc_pkg::OFF_LINE, '0);
		bus_wr(usrc_pkg::OFF_IRQ_CLR, 8'h01);
		wait_irq(1'b0);
		bus_rd(usrc_pkg::OFF_IRQ_STAT, '0);
		`CHK(d[usrc_pkg::EV_ERR], 1'b0)
		$display("test irq done");
		wrap_up();
	end
endmodule // tb
